// ===== rtl/ppl_ctrl.sv
// pixel pll input and loop control registers with detector path and feedback divider
//
// Contract
// - every control bit takes its default value on reset
// - bits 7-6 of index 00h pick one of four trigger inputs, reset 0
// - bit 5 of 00h picks reference: 0 line sync, 1 oscillator, reset 1
// - bit 4 of 00h: load divider modulus on pll reset or next line
// - bit 3 of 00h picks feedback edge: 0 rising, 1 falling
// - bit 2 of 00h picks line-sync reference edge: 0 rising, 1 falling
// - bit 1 of 00h sets coast pin level; ignored while run enable is 1
// - bit 0 of 00h low: detector coasts while coast pin active; reset 1
// - bits 5-4 of 01h post-scaler divide by 2, 4, 8, 16; reset 0
// - bits 2-0 of 01h gain code n gives 2^n microamps; reset 0
// - index 02h holds divider low byte, reset all ones
// - bit 0 of the low byte marks odd or even line length
// - bits 3-0 of index 03h are divider bits 11-8
// - divider counts programmed value plus eight clocks per line
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module ppl_ctrl #(
    parameter int DIV_W = 12
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // register port
    input  wire logic [7:0]       addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // line-sync trigger inputs, coast pin and oscillator reference
    input  wire logic [3:0]       trig_in_i,
    input  wire logic             coast_input_pin_i,
    input  wire logic             crystal_oscillator_i,
    // pixel clock enable from the pll and pll reset
    input  wire logic             pix_en_i,
    input  wire logic             pll_reset_i,
    // pll control outputs
    output ppl_pkg::ppl_input_t   input_ctrl_o,
    output ppl_pkg::ppl_loop_t    loop_ctrl_o,
    output logic      [DIV_W-1:0] fbdiv_o,
    output logic      [7:0]       gain_ua_o,
    output logic      [4:0]       post_div_o,
    output logic                  line_odd_o,
    // detector path
    output logic                  ref_event_o,
    output logic                  fb_event_o,
    output logic                  detector_active_o,
    output logic      [DIV_W:0]   fb_count_o
);

    // ****************************************
    // registers
    // ****************************************
    ppl_pkg::ppl_input_t   input_reg;
    ppl_pkg::ppl_loop_t    loop_reg;
    logic [7:0]            fbdiv_low;
    logic [3:0]            fbdiv_high;
    logic [DIV_W-1:0]      modulus;
    logic [DIV_W:0]        count;
    logic                  fb_level;
    logic                  line_sync;
    logic                  ref_src;
    logic                  coast_active;
    logic                  sync_edge;
    logic                  wrap;
    logic                  ref_mask;

    function automatic logic [7:0] read_mux(input logic [7:0] a);
        if (a == ppl_pkg::ADDR_INPUT_CTRL) begin
            read_mux = input_reg;
        end else if (a == ppl_pkg::ADDR_LOOP_CTRL) begin
            read_mux = {2'h0, loop_reg[4:3], 1'b0, loop_reg[2:0]};
        end else if (a == ppl_pkg::ADDR_FBDIV_LOW) begin
            read_mux = fbdiv_low;
        end else if (a == ppl_pkg::ADDR_FBDIV_HIGH) begin
            read_mux = {4'h0, fbdiv_high};
        end else begin
            read_mux = 8'h00;
        end
    endfunction

    // one decode shared by every register write
    function automatic logic write_hit(input logic [7:0] idx);
        write_hit = wr_i && (addr_i == idx);
    endfunction

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            input_reg <= ppl_pkg::RST_INPUT_CTRL;
        end else if (write_hit(ppl_pkg::ADDR_INPUT_CTRL)) begin
            input_reg <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loop_reg <= 5'(ppl_pkg::RST_LOOP_CTRL);
        end else if (write_hit(ppl_pkg::ADDR_LOOP_CTRL)) begin
            // reserved positions are dropped, so any value written there is harmless
            loop_reg <= {wdata_i[ppl_pkg::PSD_LSB+1:ppl_pkg::PSD_LSB],
                         wdata_i[ppl_pkg::GAIN_LSB+2:ppl_pkg::GAIN_LSB]};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fbdiv_low <= ppl_pkg::RST_FBDIV_LOW;
        end else if (write_hit(ppl_pkg::ADDR_FBDIV_LOW)) begin
            fbdiv_low <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fbdiv_high <= ppl_pkg::RST_FBDIV_HIGH;
        end else if (write_hit(ppl_pkg::ADDR_FBDIV_HIGH)) begin
            fbdiv_high <= wdata_i[3:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= read_mux(addr_i);
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ****************************************
    // direct control outputs
    // ****************************************
    assign input_ctrl_o = input_reg;
    assign loop_ctrl_o  = loop_reg;
    assign fbdiv_o      = {fbdiv_high, fbdiv_low};
    assign line_odd_o   = fbdiv_low[0];
    assign gain_ua_o    = 8'h01 << loop_reg.detector_gain_code;
    assign post_div_o   = 5'h02 << loop_reg.post_scaler_divide;

    // ****************************************
    // reference selection
    // ****************************************
    assign line_sync = trig_in_i[input_reg.trig_sel];
    assign ref_src   = input_reg.ref_is_osc ? crystal_oscillator_i : line_sync;

    ppl_edge_sel u_ref_edge (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .sig_i     (ref_src),
        .falling_i (input_reg.ref_falling),
        .edge_o    (sync_edge)
    );

    ppl_edge_sel u_fb_edge (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .sig_i     (fb_level),
        .falling_i (input_reg.fb_falling),
        .edge_o    (fb_event_o)
    );

    // coast pin level only matters when run enable is clear
    assign coast_active = coast_input_pin_i ^ input_reg.coast_pin_polarity;
    assign detector_active_o = input_reg.detector_run_enable | ~coast_active;
    assign ref_event_o = sync_edge & detector_active_o & ~ref_mask;

    // ****************************************
    // reference switch guard
    // ****************************************
    // a write to 00h may swap source or edge under the detector, and reset leaves its
    // history at zero; the edge seen in the next cycle is dropped, at the cost of a
    // real edge that falls in that very cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_mask <= 1'b1;
        end else begin
            ref_mask <= write_hit(ppl_pkg::ADDR_INPUT_CTRL);
        end
    end

    // ****************************************
    // feedback divider
    // ****************************************
    // modulus is the programmed value plus eight pixel clocks
    localparam logic [DIV_W:0] FBDIV_EXTRA_W = (DIV_W+1)'(ppl_pkg::FBDIV_EXTRA);
    assign wrap = (count == ({1'b0, modulus} + FBDIV_EXTRA_W - 1'b1));

    // shadow modulus: a mid-line rewrite cannot tear the running count
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            modulus <= {ppl_pkg::RST_FBDIV_HIGH, ppl_pkg::RST_FBDIV_LOW};
        end else if (input_reg.load_on_line ? (pix_en_i && wrap) : pll_reset_i) begin
            modulus <= {fbdiv_high, fbdiv_low};
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count    <= '0;
            fb_level <= 1'b0;
        end else if (pll_reset_i) begin
            count    <= '0;
            fb_level <= 1'b0;
        end else if (pix_en_i) begin
            count    <= wrap ? '0 : count + 1'b1;
            fb_level <= (count < {1'b0, modulus[DIV_W-1:1]});
        end
    end

    assign fb_count_o = count;

endmodule

// ===== rtl/ppl_edge_sel.sv
// selectable edge detector used for reference and feedback phase events
`timescale 1ns/1ps
module ppl_edge_sel (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // signal and choice
    input  wire logic sig_i,
    input  wire logic falling_i,
    // event
    output logic      edge_o
);

    logic sig_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sig_q <= 1'b0;
        end else begin
            sig_q <= sig_i;
        end
    end

    assign edge_o = falling_i ? (sig_q & ~sig_i) : (~sig_q & sig_i);

endmodule

// ===== rtl/ppl_pkg.sv
// constants and carrier types for the pixel pll input and loop control block
package ppl_pkg;

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [7:0] ADDR_INPUT_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LOOP_CTRL  = 8'h01;
    localparam logic [7:0] ADDR_FBDIV_LOW  = 8'h02;
    localparam logic [7:0] ADDR_FBDIV_HIGH = 8'h03;

    // ****************************************
    // field positions
    // ****************************************
    localparam int TRIG_SEL_LSB   = 6;
    localparam int REF_SEL_BIT    = 5;
    localparam int LOAD_LINE_BIT  = 4;
    localparam int FB_EDGE_BIT    = 3;
    localparam int REF_EDGE_BIT   = 2;
    localparam int COAST_POL_BIT  = 1;
    localparam int RUN_EN_BIT     = 0;
    localparam int PSD_LSB        = 4;
    localparam int GAIN_LSB       = 0;

    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [7:0] RST_INPUT_CTRL = 8'h21;
    localparam logic [7:0] RST_LOOP_CTRL  = 8'h00;
    localparam logic [7:0] RST_FBDIV_LOW  = 8'hFF;
    localparam logic [3:0] RST_FBDIV_HIGH = 4'h0;
    localparam logic [7:0] MASK_LOOP_CTRL = 8'h37;
    localparam logic [7:0] MASK_FBDIV_HI  = 8'h0F;

    // ****************************************
    // timing
    // ****************************************
    localparam logic [12:0] FBDIV_EXTRA   = 13'h0008;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic [1:0] trig_sel;
        logic       ref_is_osc;
        logic       load_on_line;
        logic       fb_falling;
        logic       ref_falling;
        logic       coast_pin_polarity;
        logic       detector_run_enable;
    } ppl_input_t;

    typedef struct packed {
        logic [1:0] post_scaler_divide;
        logic [2:0] detector_gain_code;
    } ppl_loop_t;

endpackage

// ===== testbench/ppl_ctrl_props.sv
// port assertions for the pixel pll control block
`timescale 1ns/1ps
module ppl_ctrl_props #(
    parameter int DIV_W = 12
) (
    input wire logic                clk_i,
    input wire logic                arst_n_i,
    input wire logic [7:0]          addr_i,
    input wire logic [7:0]          wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                coast_input_pin_i,
    input wire ppl_pkg::ppl_input_t input_ctrl_o,
    input wire ppl_pkg::ppl_loop_t  loop_ctrl_o,
    input wire logic [DIV_W-1:0]    fbdiv_o,
    input wire logic [7:0]          gain_ua_o,
    input wire logic [4:0]          post_div_o,
    input wire logic                detector_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read slot");
    AST_RD_IN: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == $past(input_ctrl_o))
        else $error("index 00 readback");
    AST_WR_IN: assert property (wr_i && addr_i == 8'h00 |=> input_ctrl_o == $past(wdata_i))
        else $error("index 00 write");
    AST_WR_LOOP: assert property (wr_i && addr_i == 8'h01 |=>
        loop_ctrl_o == {$past(wdata_i[5:4]), $past(wdata_i[2:0])})
        else $error("index 01 write");
    AST_WR_LOW: assert property (wr_i && addr_i == 8'h02 |=> fbdiv_o[7:0] == $past(wdata_i))
        else $error("index 02 write");
    AST_GAIN: assert property ($onehot(gain_ua_o) && gain_ua_o[loop_ctrl_o.detector_gain_code])
        else $error("gain decode");
    AST_POST: assert property ($onehot(post_div_o) &&
        post_div_o[loop_ctrl_o.post_scaler_divide + 3'h1])
        else $error("post divide decode");
    AST_COAST: assert property (detector_active_o == (input_ctrl_o.detector_run_enable ||
        coast_input_pin_i == input_ctrl_o.coast_pin_polarity))
        else $error("coast gating");
endmodule
bind ppl_ctrl ppl_ctrl_props #(.DIV_W(DIV_W)) u_props (.clk_i, .arst_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .coast_input_pin_i, .input_ctrl_o, .loop_ctrl_o, .fbdiv_o,
    .gain_ua_o, .post_div_o, .detector_active_o);

// ===== testbench/ppl_video_src.sv
// video source model: line sync triggers, coast pin, oscillator, pixel enable
`timescale 1ns/1ps
module ppl_video_src (
    input  wire logic       clk_i,
    input  wire logic       coast_req_i,
    output logic      [3:0] trig_o   = 4'h0,
    output logic            coast_o  = 1'h0,
    output logic            osc_o    = 1'h0,
    output logic            pix_en_o = 1'h0
);
    logic [4:0] cnt = 5'h00;
    always_ff @(posedge clk_i) begin
        cnt      <= cnt + 5'h01;
        // one short sync pulse per 32 clocks, on trigger path 2 only, so a wrong select is silent
        trig_o   <= {1'h0, cnt < 5'h04, 2'h0};
        osc_o    <= cnt[2];
        coast_o  <= coast_req_i;
        pix_en_o <= 1'h1;
    end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the pixel pll control registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    logic                clk_i = 1'h0;
    logic                arst_n_i = 1'h0;
    logic [7:0]          addr_i = 8'h00;
    logic [7:0]          wdata_i = 8'h00;
    logic                wr_i = 1'h0;
    logic                rd_i = 1'h0;
    logic                pll_reset_i = 1'h0;
    logic                coast_req = 1'h0;
    logic [7:0]          rdata_o, gain_ua_o;
    logic [3:0]          trig;
    logic                coast, osc, pix_en, line_odd_o, fb_event_o, detector_active_o;
    logic                ref_event_o;
    logic [12:0]         fb_count_o;
    ppl_pkg::ppl_input_t input_ctrl_o;
    ppl_pkg::ppl_loop_t  loop_ctrl_o;
    logic [11:0]         fbdiv_o;
    logic [4:0]          post_div_o;
    int                  num_errors = 0;
    int                  n_tests = 0;
    int                  gap;
    initial forever #20 clk_i = ~clk_i;
    ppl_video_src u_src (.clk_i, .coast_req_i(coast_req), .trig_o(trig), .coast_o(coast),
        .osc_o(osc), .pix_en_o(pix_en));
    ppl_ctrl #(.DIV_W(12)) u_dut (.clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .trig_in_i(trig), .coast_input_pin_i(coast), .crystal_oscillator_i(osc),
        .pix_en_i(pix_en), .pll_reset_i, .input_ctrl_o, .loop_ctrl_o, .fbdiv_o, .gain_ua_o,
        .post_div_o, .line_odd_o, .ref_event_o, .fb_event_o, .detector_active_o,
        .fb_count_o);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'h1;
        @(posedge clk_i);
        wr_i    <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'h1;
        @(posedge clk_i);
        rd_i   <= 1'h0;
        #1;
        `CHK("rdata", e, rdata_o)
    endtask
    // pin change crosses the source model register before the block sees it
    task automatic pin(input logic v, input logic e);
        @(posedge clk_i);
        coast_req <= v;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("detector", e, detector_active_o)
    endtask
    // two sync periods hold 2 line edges or 8 oscillator edges; each event must sit
    // on the level that its chosen edge leads to
    task automatic refs(input logic [7:0] c, input int e, input logic lvl);
        int seen;
        wr(8'h00, c);
        repeat (2) @(negedge clk_i);
        seen = 0;
        repeat (64) begin
            @(negedge clk_i);
            if (ref_event_o === 1'h1) begin
                seen++;
                `CHK("ref level", lvl, (c[5] ? osc : trig[2]))
            end
        end
        `CHK("ref count", e, seen)
    endtask
    // skips two feedback events so a pending modulus load has landed, then times a period
    task automatic period(input int e);
        repeat (2) begin
            gap = 0;
            do begin @(negedge clk_i); gap++; end while (fb_event_o !== 1'h1 && gap < 9000);
        end
        gap = 0;
        do begin @(negedge clk_i); gap++; end while (fb_event_o !== 1'h1 && gap < 40);
        `CHK("period", e, gap)
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'h1;
        rd(8'h00, 8'h21);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'hFF);
        rd(8'h03, 8'h00);
        rd(8'h10, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, {c[1:0], 6'h2A});
            rd(8'h00, {c[1:0], 6'h2A});
        end
        wr(8'h10, 8'hFF);
        rd(8'h00, 8'hEA);
        pin(1'h1, 1'h1);
        pin(1'h0, 1'h0);
        wr(8'h00, 8'h00);
        pin(1'h1, 1'h0);
        wr(8'h00, 8'h01);
        pin(1'h1, 1'h1);
        refs(8'h81, 2, 1'h1);
        refs(8'h85, 2, 1'h0);
        refs(8'h01, 0, 1'h1);
        refs(8'hA1, 8, 1'h1);
        refs(8'h80, 0, 1'h1);
        refs(8'h82, 2, 1'h1);
        $display("test input control done");
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h37);
        for (int n = 0; n < 8; n++) begin
            wr(8'h01, {2'h0, n[1:0], 1'h0, n[2:0]});
            `CHK("gain", 8'h01 << n, gain_ua_o)
            `CHK("post", 5'h02 << n[1:0], post_div_o)
        end
        $display("test loop control done");
        wr(8'h02, 8'h55);
        wr(8'h03, 8'hFA);
        rd(8'h03, 8'h0A);
        `CHK("divider", 12'hA55, fbdiv_o)
        `CHK("odd", 1'h1, line_odd_o)
        wr(8'h02, 8'h04);
        wr(8'h03, 8'h00);
        `CHK("odd", 1'h0, line_odd_o)
        @(posedge clk_i);
        pll_reset_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        pll_reset_i <= 1'h0;
        #1;
        `CHK("count", 13'h0000, fb_count_o)
        period(4 + 8);
        wr(8'h02, 8'h08);
        period(4 + 8);
        wr(8'h00, 8'h10);
        period(8 + 8);
        $display("test divider done");
        @(posedge clk_i);
        arst_n_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'h1;
        rd(8'h00, 8'h21);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'hFF);
        $display("test second reset done");
        end_of_test();
    end
endmodule
